//--- dv/test_zqct_top.sv
// self-checking bench for the calibration and termination block
// assumes the model drives cmd and pin, the bench drives apb
`include "zqct_consts.svh"
`timescale 1ns/1ps
module test_zqct_top;
  import zqct_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, pin;
  logic cal_busy_r, cal_current_on_r, term_enable_r;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] engine_result, driver_impedance_r, term_cal_r;
  zqct_cmd_t cmd;
  zqct_term_t term_r;
  int bad_count, samples_checked;
  zqct_top uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd(cmd), .termination_control_pin(pin),
    .engine_result(engine_result), .driver_impedance_r(driver_impedance_r),
    .term_cal_r(term_cal_r), .cal_busy_r(cal_busy_r), .cal_current_on_r(cal_current_on_r),
    .term_enable_r(term_enable_r), .term_r(term_r));
  zqct_ctrl_model ctl (.clk(clk), .cal_busy_r(cal_busy_r), .cmd(cmd),
    .termination_control_pin(pin));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) begin
      bad_count++;
      tally_and_finish();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rchk(input string w, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(w, exp, q & m);
  endtask
  task automatic test_regs;
    logic [31:0] q;
    logic e;
    chk("drv_rst", 32'h80, 32'(driver_impedance_r));
    rchk("stat_rst", `ZQCT_A_STAT, 32'h3FB, 32'h0);
    wreg(`ZQCT_A_MR5, 32'h1C0);
    rchk("mr5", `ZQCT_A_MR5, 32'h1FFF, 32'h1C0);
    wreg(`ZQCT_A_STAT, 32'hFFFFFFFF);
    rchk("stat_ro", `ZQCT_A_STAT, 32'h3FB, 32'h0);
    apb(1'b0, 12'h018, 32'h0, q, e);
    chk("unmapped", 32'h1, 32'(e));
    $display("test_regs done");
  endtask
  task automatic cal_case(input string w, input logic lng, input logic [7:0] res,
      input int win, input logic [7:0] exp);
    int n;
    engine_result <= res;
    fork
      ctl.cal(lng, n);
      begin
        repeat (6) @(posedge clk);
        chk({w, "_term"}, 32'(ZQCT_OFF), 32'(term_r.src));
        chk({w, "_cur_on"}, 32'h1, 32'(cal_current_on_r));
      end
    join
    chk({w, "_win"}, 32'h1, 32'(n >= win - 2 && n <= win + 1));
    chk({w, "_drv"}, 32'(exp), 32'(driver_impedance_r));
    chk({w, "_term_cal"}, 32'(exp), 32'(term_cal_r));
    chk({w, "_cur_off"}, 32'h0, 32'(cal_current_on_r));
    $display("cal %s done", w);
  endtask
  task automatic test_refresh;
    zqct_cmd_t c;
    wreg(`ZQCT_A_MR1, 32'hA00);
    ctl.set_pin(1'b1);
    c = '0;
    c.sr_enter = 1'b1;
    ctl.pulse(c);
    repeat (3) @(posedge clk);
    chk("sr_term", 32'(ZQCT_OFF), 32'(term_r.src));
    rchk("sr_stat", `ZQCT_A_STAT, 32'h100, 32'h100);
    ctl.leave_sr();
    repeat (20) @(posedge clk);
    chk("sr_codes", 32'h5B, 32'(driver_impedance_r));
    chk("sr_nom", 32'(ZQCT_NOM), 32'(term_r.src));
    $display("test_refresh done");
  endtask
  task automatic test_term;
    zqct_term_t e;
    zqct_cmd_t c;
    logic [2:0] nom, park;
    for (int i = 0; i < 16; i++) begin
      nom = i[1] ? 3'h2 : 3'h0;
      park = i[2] ? 3'h5 : 3'h0;
      wreg(`ZQCT_A_MR1, {20'h0, i[3], nom, 8'h00});
      wreg(`ZQCT_A_MR2, {20'h0, 3'h3, 9'h000});
      wreg(`ZQCT_A_MR5, {23'h0, park, 6'h00});
      ctl.set_pin(i[0]);
      repeat (3) @(posedge clk);
      e = '{ZQCT_OFF, 3'h0};
      if (i[3] && park != 0) e = '{ZQCT_PARK, park};
      if (i[3] && i[0] && nom != 0) e = '{ZQCT_NOM, nom};
      chk("term_idle", 32'(e), 32'(term_r));
      if (i[3]) chk("term_en", 32'h1, 32'(term_enable_r));
      c = '0;
      c.wr_cmd = 1'b1;
      ctl.pulse(c);
      repeat (2) @(posedge clk);
      e = i[3] ? '{ZQCT_WR, 3'h3} : '{ZQCT_OFF, 3'h0};
      chk("term_wr", 32'(e), 32'(term_r));
      c = '0;
      c.rd_cmd = 1'b1;
      ctl.pulse(c);
      repeat (2) @(posedge clk);
      chk("term_rd", 32'(ZQCT_OFF), 32'(term_r.src));
      repeat (8) @(posedge clk);
    end
    wreg(`ZQCT_A_MR1, 32'h800);
    wreg(`ZQCT_A_MR2, 32'h0);
    wreg(`ZQCT_A_MR5, 32'h0);
    repeat (3) @(posedge clk);
    chk("term_en_off", 32'h0, 32'(term_enable_r));
    $display("test_term done");
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    engine_result = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    test_regs();
    wreg(`ZQCT_A_MR1, 32'h800);
    cal_case("first", 1'b1, 8'h3C, `ZQCT_FIRST_CAL_CYC, 8'h3C);
    rchk("first_done", `ZQCT_A_STAT, 32'h200, 32'h200);
    cal_case("second", 1'b1, 8'h5A, `ZQCT_LONG_CAL_CYC, 8'h5A);
    cal_case("short", 1'b0, 8'h60, `ZQCT_SHORT_CAL_CYC, 8'h5B);
    test_refresh();
    test_term();
    tally_and_finish();
  end
endmodule

//--- dv/zqct_ctrl_model.sv
// controller-side model: calibration commands and the termination pin
// assumes the device samples cmd and the pin on rising clk edges
`timescale 1ns/1ps
module zqct_ctrl_model
  import zqct_pkg::*;
#(
  parameter int SR_EXIT_CYC = 10
) (
  input wire logic clk,
  input wire logic cal_busy_r,
  output zqct_cmd_t cmd,
  output logic termination_control_pin
);
  initial begin
    cmd = '0;
    termination_control_pin = 1'b0;
  end
  task automatic pulse(input zqct_cmd_t c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
  endtask
  task automatic set_pin(input logic v);
    @(posedge clk);
    termination_control_pin <= v;
  endtask
  // banks counted as precharged; nothing else is sent while busy
  task automatic cal(input logic lng, output int n);
    zqct_cmd_t c;
    c = '0;
    c.long_cal = lng;
    c.short_cal = !lng;
    pulse(c);
    n = 0;
    @(posedge clk);
    while (cal_busy_r === 1'b1 && n < 1000) begin
      n++;
      @(posedge clk);
    end
  endtask
  task automatic leave_sr;
    zqct_cmd_t c;
    c = '0;
    c.sr_exit = 1'b1;
    pulse(c);
    repeat (SR_EXIT_CYC) @(posedge clk);
  endtask
endmodule

//--- hw/zqct_consts.svh
// constants for the calibration and termination block
// assumes inclusion by the bench and zqct_top
`ifndef ZQCT_CONSTS_SVH
`define ZQCT_CONSTS_SVH
`define ZQCT_CLK_NS 10
`define ZQCT_FIRST_CAL_NS 1024
`define ZQCT_LONG_CAL_NS 512
`define ZQCT_SHORT_CAL_NS 128
`define ZQCT_FIRST_CAL_CYC ((`ZQCT_FIRST_CAL_NS + `ZQCT_CLK_NS - 1) / `ZQCT_CLK_NS)
`define ZQCT_LONG_CAL_CYC ((`ZQCT_LONG_CAL_NS + `ZQCT_CLK_NS - 1) / `ZQCT_CLK_NS)
`define ZQCT_SHORT_CAL_CYC ((`ZQCT_SHORT_CAL_NS + `ZQCT_CLK_NS - 1) / `ZQCT_CLK_NS)
`define ZQCT_SHORT_STEP_CYC 64
`define ZQCT_ENGINE_CYC 8
`define ZQCT_READ_OFF_CYC 6
`define ZQCT_WRITE_ON_CYC 6
`define ZQCT_A_CTRL 12'h000
`define ZQCT_A_MR1 12'h004
`define ZQCT_A_MR2 12'h008
`define ZQCT_A_MR5 12'h00C
`define ZQCT_A_STAT 12'h010
`define ZQCT_A_CAL 12'h014
`define ZQCT_MR1_TEN 11
`define ZQCT_MR1_NOM_LO 8
`define ZQCT_MR2_WR_LO 9
`define ZQCT_MR5_PARK_LO 6
`define ZQCT_CAL_RST 8'h80
`endif

//--- hw/zqct_pkg.sv
// types for the calibration and termination block
// assumes zqct_consts.svh is on the include path
package zqct_pkg;
  typedef enum logic [1:0] {ZQCT_OFF, ZQCT_WR, ZQCT_NOM, ZQCT_PARK} zqct_src_t;
  typedef enum logic [1:0] {ZQCT_IDLE, ZQCT_ENGINE, ZQCT_HOLD} zqct_state_t;
  typedef struct packed {
    logic long_cal;
    logic short_cal;
    logic wr_cmd;
    logic rd_cmd;
    logic sr_enter;
    logic sr_exit;
  } zqct_cmd_t;
  typedef struct packed {
    zqct_src_t src;
    logic [2:0] code;
  } zqct_term_t;
endpackage

//--- hw/zqct_term_sel.sv
// termination priority resolver, purely combinational
// assumes mode fields are already decoded by the caller
`timescale 1ns/1ps
module zqct_term_sel
  import zqct_pkg::*;
(
  input wire logic disable_all,
  input wire logic wr_active,
  input wire logic pin_high,
  input wire logic pin_valid,
  input wire logic [2:0] nom_code,
  input wire logic [2:0] wr_code,
  input wire logic [2:0] park_code,
  output zqct_term_t term
);
  always_comb begin
    // fixed priority: disable, write, nominal, parked
    if (disable_all) begin // R21
      term = '{ZQCT_OFF, 3'h0};
    end else if (wr_active && wr_code != 3'h0) begin // R18
      term = '{ZQCT_WR, wr_code};
    end else if (pin_valid && pin_high && nom_code != 3'h0) begin // R19
      term = '{ZQCT_NOM, nom_code};
    end else if (park_code != 3'h0) begin // R20
      term = '{ZQCT_PARK, park_code};
    end else begin
      term = '{ZQCT_OFF, 3'h0};
    end
  end
endmodule

//--- hw/zqct_top.sv
// calibration sequencer, termination control and register slave
// assumes commands arrive decoded, one-cycle pulses on clk; apb on clk
//
// Behaviour
// R1 - long calibration runs the engine, then loads driver and termination codes
// R2 - controller may send long calibration whenever it likes; the sequencer drops one that arrives while a calibration is busy
// R3 - first long calibration after reset gets the longer first window
// R4 - short calibration finishes inside its window, correcting within 64 cycles
// R5 - controller keeps the channel quiet during every calibration window
// R6 - calibration current path is switched off once calibration is done
// R7 - controller precharges all banks before any calibration command
// R8 - no self-started calibration after self refresh exit
// R9 - controller waits the self refresh exit delay before calibrating
// R10 - devices sharing a resistor never overlap calibration windows
// R11 - clock enable stays high for the whole calibration
// R12 - termination is forced off during calibration
// R13 - all bus devices leave data lines floating during calibration
// R14 - per-lane termination only when mode register one enable bit is set
// R15 - termination is off in self refresh
// R16 - pin ignored in self refresh or when nominal bits 9,6,2 are zero
// R17 - termination mode active when any of three fields is non-zero
// R18 - write termination applied on writes regardless of pin
// R19 - nominal termination on when pin sampled high, unless disabled
// R20 - parked termination is default when nominal is not active
// R21 - priority: disable, write, nominal, parked
// R22 - termination off for a fixed window during reads
// R23 - flag set by first long calibration selects window length
`include "zqct_consts.svh"
`timescale 1ns/1ps
module zqct_top
  import zqct_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire zqct_cmd_t cmd,
  input wire logic termination_control_pin,
  input wire logic [7:0] engine_result,
  output logic [7:0] driver_impedance_r,
  output logic [7:0] term_cal_r,
  output logic cal_busy_r,
  output logic cal_current_on_r,
  output logic term_enable_r,
  output zqct_term_t term_r
);
  localparam int FIRST_CYC = `ZQCT_FIRST_CAL_CYC;
  localparam int LONG_CYC = `ZQCT_LONG_CAL_CYC;
  localparam int SHORT_CYC = `ZQCT_SHORT_CAL_CYC;

  logic [12:0] mode_one_r;
  logic [12:0] mode_two_r;
  logic [12:0] mode_five_r;
  logic first_done_r;
  logic self_refresh_r;
  logic [15:0] win_cnt_r;
  logic [15:0] win_cnt_nxt;
  logic [3:0] eng_cnt_r;
  logic is_short_r;
  zqct_state_t state_r;
  logic [3:0] rd_cnt_r;
  logic [3:0] wr_cnt_r;
  logic [7:0] cal_count_r;
  zqct_term_t term_nxt;
  logic access;
  logic nom_enabled;
  logic pin_valid;

  function automatic logic [15:0] win_len(input logic short_c, input logic first_c);
    if (short_c) begin
      win_len = 16'(SHORT_CYC);
    end else if (first_c) begin
      win_len = 16'(FIRST_CYC);
    end else begin
      win_len = 16'(LONG_CYC);
    end
  endfunction

  assign access = psel && penable;

  // apb: zero wait states, unmapped addresses raise pslverr
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `ZQCT_A_MR1: prdata <= {19'h0, mode_one_r};
          `ZQCT_A_MR2: prdata <= {19'h0, mode_two_r};
          `ZQCT_A_MR5: prdata <= {19'h0, mode_five_r};
          // bit 2 is a reserved gap that reads zero
          `ZQCT_A_STAT: prdata <= {22'h0, first_done_r, self_refresh_r, term_r.src,
                                  term_r.code, 1'b0, cal_busy_r, cal_current_on_r};
          `ZQCT_A_CAL: prdata <= {8'h0, cal_count_r, term_cal_r, driver_impedance_r};
          `ZQCT_A_CTRL: prdata <= 32'h0;
          default: prdata <= 32'h0;
        endcase
      end
      if (psel && !penable) begin
        case (paddr)
          `ZQCT_A_CTRL, `ZQCT_A_MR1, `ZQCT_A_MR2, `ZQCT_A_MR5, `ZQCT_A_STAT,
          `ZQCT_A_CAL: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // mode registers written by software stand in for mode_register_set_cmd
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_one_r <= 13'h0;
      mode_two_r <= 13'h0;
      mode_five_r <= 13'h0;
    end else if (access && pready && pwrite) begin
      case (paddr)
        `ZQCT_A_MR1: mode_one_r <= pwdata[12:0];
        `ZQCT_A_MR2: mode_two_r <= pwdata[12:0];
        `ZQCT_A_MR5: mode_five_r <= pwdata[12:0];
        default: mode_one_r <= mode_one_r;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      self_refresh_r <= 1'b0;
    end else if (cmd.sr_enter) begin
      self_refresh_r <= 1'b1;
    end else if (cmd.sr_exit) begin
      // exit starts nothing; calibration waits for a command
      self_refresh_r <= 1'b0; // R8
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_done_r <= 1'b0;
    end else if (cmd.long_cal && state_r == ZQCT_IDLE) begin
      first_done_r <= 1'b1; // R23
    end
  end

  always_comb begin
    win_cnt_nxt = win_cnt_r;
    if (state_r != ZQCT_IDLE && win_cnt_r != 16'h0) begin
      win_cnt_nxt = win_cnt_r - 16'h1;
    end
  end

  // calibration sequencer; commands arriving while busy are dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ZQCT_IDLE;
      win_cnt_r <= 16'h0;
      eng_cnt_r <= 4'h0;
      is_short_r <= 1'b0;
      cal_busy_r <= 1'b0;
      cal_current_on_r <= 1'b0;
    end else begin
      win_cnt_r <= win_cnt_nxt;
      case (state_r)
        ZQCT_IDLE: begin
          if (cmd.long_cal || cmd.short_cal) begin
            state_r <= ZQCT_ENGINE;
            is_short_r <= cmd.short_cal && !cmd.long_cal;
            win_cnt_r <= win_len(cmd.short_cal && !cmd.long_cal, !first_done_r); // R3
            eng_cnt_r <= 4'(`ZQCT_ENGINE_CYC);
            cal_busy_r <= 1'b1;
            cal_current_on_r <= 1'b1;
          end
        end
        ZQCT_ENGINE: begin
          eng_cnt_r <= eng_cnt_r - 4'h1;
          if (eng_cnt_r == 4'h1) begin
            state_r <= ZQCT_HOLD;
            cal_current_on_r <= 1'b0; // R6
          end
        end
        ZQCT_HOLD: begin
          if (win_cnt_r <= 16'h1) begin
            state_r <= ZQCT_IDLE;
            cal_busy_r <= 1'b0;
          end
        end
        default: state_r <= ZQCT_IDLE;
      endcase
    end
  end

  // transfer to the i/o at the end of the engine phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      driver_impedance_r <= `ZQCT_CAL_RST;
      term_cal_r <= `ZQCT_CAL_RST;
      cal_count_r <= 8'h0;
    end else if (state_r == ZQCT_ENGINE && eng_cnt_r == 4'h1) begin
      cal_count_r <= cal_count_r + 8'h1;
      if (is_short_r) begin
        // one short step moves codes at most one lsb toward the target
        driver_impedance_r <= driver_impedance_r + 8'((engine_result > driver_impedance_r) ?
                              1 : (engine_result < driver_impedance_r) ? -1 : 0); // R4
        term_cal_r <= term_cal_r + 8'((engine_result > term_cal_r) ?
                      1 : (engine_result < term_cal_r) ? -1 : 0); // R4
      end else begin
        driver_impedance_r <= engine_result; // R1
        term_cal_r <= engine_result; // R1
      end
    end
  end

  // read and write termination windows, started by the command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_cnt_r <= 4'h0;
      wr_cnt_r <= 4'h0;
    end else begin
      if (cmd.rd_cmd) begin
        rd_cnt_r <= 4'(`ZQCT_READ_OFF_CYC); // R22
      end else if (rd_cnt_r != 4'h0) begin
        rd_cnt_r <= rd_cnt_r - 4'h1;
      end
      if (cmd.wr_cmd) begin
        wr_cnt_r <= 4'(`ZQCT_WRITE_ON_CYC); // R18
      end else if (wr_cnt_r != 4'h0) begin
        wr_cnt_r <= wr_cnt_r - 4'h1;
      end
    end
  end

  assign nom_enabled = mode_one_r[`ZQCT_MR1_NOM_LO +: 3] != 3'h0; // R17
  // pin ignored when bits 9,6,2 are zero or in self refresh
  assign pin_valid = !self_refresh_r
                     && {mode_one_r[9], mode_one_r[6], mode_one_r[2]} != 3'h0; // R16

  zqct_term_sel u_sel (
    // the read command itself blocks too, so termination is off from the next edge
    .disable_all(cal_busy_r || self_refresh_r || rd_cnt_r != 4'h0 || cmd.rd_cmd
                 || !mode_one_r[`ZQCT_MR1_TEN]), // R12 R14 R15 R22
    .wr_active(wr_cnt_r != 4'h0 || cmd.wr_cmd),
    .pin_high(termination_control_pin),
    .pin_valid(pin_valid && nom_enabled), // R19
    .nom_code(mode_one_r[`ZQCT_MR1_NOM_LO +: 3]),
    .wr_code(mode_two_r[`ZQCT_MR2_WR_LO +: 3]),
    .park_code(mode_five_r[`ZQCT_MR5_PARK_LO +: 3]),
    .term(term_nxt)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      term_r <= '{ZQCT_OFF, 3'h0};
      term_enable_r <= 1'b0;
    end else begin
      term_r <= term_nxt; // R21
      // mode is on when any of the three resistance fields is programmed
      term_enable_r <= nom_enabled
                       || mode_two_r[`ZQCT_MR2_WR_LO +: 3] != 3'h0
                       || mode_five_r[`ZQCT_MR5_PARK_LO +: 3] != 3'h0; // R17
    end
  end

  sel_cal_a: assert property (@(posedge clk) disable iff (sys_rst)
    cal_busy_r |-> term_r.src == ZQCT_OFF || $rose(cal_busy_r)) // R12
    else $error("termination on during calibration");
  sel_sr_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(self_refresh_r) |-> term_r.src == ZQCT_OFF) // R15
    else $error("termination on in self refresh");
  first_win_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ZQCT_IDLE && cmd.long_cal && !first_done_r |=> win_cnt_r == 16'(FIRST_CYC)) // R3
    else $error("first window length wrong");
  flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ZQCT_IDLE && cmd.long_cal |=> first_done_r) // R23
    else $error("first flag not set");
  cur_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ZQCT_HOLD |-> !cal_current_on_r) // R6
    else $error("current path still on");
  sequence load_s;
    state_r == ZQCT_ENGINE && eng_cnt_r == 4'h1 && !is_short_r;
  endsequence
  load_a: assert property (@(posedge clk) disable iff (sys_rst)
    load_s |=> driver_impedance_r == $past(engine_result)) // R1
    else $error("long result not loaded");
  short_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(cal_busy_r) && is_short_r |-> ##[1:64] !cal_busy_r) // R4
    else $error("short calibration overran");
  no_self_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cmd.long_cal && !cmd.short_cal && state_r == ZQCT_IDLE |=> !cal_busy_r) // R8
    else $error("calibration started without command");
  rd_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd.rd_cmd |=> term_r.src == ZQCT_OFF [*6]) // R22
    else $error("termination on during read");
  wr_pri_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd.wr_cmd && !cal_busy_r && !self_refresh_r && rd_cnt_r == 4'h0 && mode_one_r[11]
    && mode_two_r[11:9] != 3'h0 |=> term_r.src == ZQCT_WR) // R18
    else $error("write termination not applied");
endmodule
